/* hw/spt_defines.svh */
/*
 Register offsets, field positions, reset values and timing counts of the
 session protocol timer. Assumes a 125 MHz core clock and a byte-addressed
 16-bit register port.
*/
`ifndef SPT_DEFINES_SVH
`define SPT_DEFINES_SVH

// ==========================================================
// Register offsets
`define SPT_ADDR_W 8
`define SPT_DATA_W 16
`define SPT_OFF_FALL_EN_SET 8'hF0
`define SPT_OFF_FALL_EN_CLR 8'hF2
`define SPT_OFF_RISE_EN_SET 8'hF4
`define SPT_OFF_RISE_EN_CLR 8'hF6
`define SPT_OFF_TMR_LO_SET 8'hF8
`define SPT_OFF_TMR_LO_CLR 8'hFA
`define SPT_OFF_TMR_HI_SET 8'hFC
`define SPT_OFF_TMR_HI_CLR 8'hFE
`define SPT_OFF_IRQ_STAT 8'hE4
`define SPT_OFF_IRQ_MASK 8'hE6

// ==========================================================
// Field positions
`define SPT_BIT_RUN_HI 15
`define SPT_BIT_TMO_EN 9
`define SPT_LOAD_W 24
`define SPT_LOAD_HI_W 8
`define SPT_IRQ_W 2
`define SPT_IRQ_RISE 0
`define SPT_IRQ_FALL 1

// ==========================================================
// Reset values
`define SPT_RST_LOAD 24'h000000
`define SPT_RST_IRQ 2'h0

// ==========================================================
// Timing
`define SPT_CLK_PERIOD_PS 8000
`define SPT_TICK_PS 10000000
`define SPT_TICK_CYC (`SPT_TICK_PS / `SPT_CLK_PERIOD_PS)
`define SPT_PRE_W 11

`endif

/* hw/spt_pkg.sv */
/*
 Types of the session protocol timer: control states and the register
 port request carrier. Assumes spt_defines.svh for the widths.
*/
`include "spt_defines.svh"

package spt_pkg;

   // ==========================================================
   // Timer states, Gray coded along idle, count, expired
   typedef enum logic [1:0] {
      SPT_IDLE = 2'b00,
      SPT_COUNT = 2'b01,
      SPT_EXPIRED = 2'b11
   } spt_state_t;

   // ==========================================================
   // Register port request
   typedef struct packed {
      logic [`SPT_ADDR_W-1:0] addr;
      logic [`SPT_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } spt_req_t;

endpackage : spt_pkg

/* hw/spt_timer.sv */
/*
 Session protocol timer: 24-bit one-shot timer with split set/clear
 register halves, timeout edge interrupt enables and an interrupt
 status/mask pair.
 Assumes one 125 MHz clock, a synchronous reset and a register master
 on the same clock that never issues read and write at once, that
 takes read data in the single cycle after its read strobe, and that
 programs the start value before it writes the run bit.
*/
// The strobed register port was decided locally.
// Operation
// R1 - Timer state is 32 bits, reached as separate 16-bit low and high halves.
// R2 - Low half answers at set address F8h and clear address FAh.
// R3 - High half answers at set address FCh and clear address FEh.
// R4 - Run bit 31 going to one loads the 24-bit start value and counts.
// R5 - Software clearing the run bit halts the timer.
// R6 - Hardware clears the run bit itself on timeout.
// R7 - Bits 23 to 0 hold the start value, programmed before starting.
// R8 - One start value unit equals one 0.01 ms tick.
// R9 - Timeout rise or fall interrupts only when bit 9 enable is set.
// R10 - Tick from core clock, count down per tick, timeout level at zero.
`timescale 1ns/1ps
`include "spt_defines.svh"
`default_nettype none

module spt_timer
   import spt_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // Register port
   input wire logic [`SPT_ADDR_W-1:0] ADDR,
   input wire logic [`SPT_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [`SPT_DATA_W-1:0] RDATA,
   // Status
   output logic TIMEOUT,
   output logic IRQ
);

   // ==========================================================
   // Request carrier
   spt_req_t req;

   assign req.addr = ADDR;
   assign req.wdata = WDATA;
   assign req.wr = WR;
   assign req.rd = RD;

   // ==========================================================
   // Address decode
   logic wr_lo_set;
   logic wr_lo_clr;
   logic wr_hi_set;
   logic wr_hi_clr;
   logic wr_fen_set;
   logic wr_fen_clr;
   logic wr_ren_set;
   logic wr_ren_clr;
   logic wr_stat;
   logic wr_mask;

   // Exact decode, so odd and unlisted addresses fall through unmapped
   assign wr_lo_set = req.wr && (req.addr == `SPT_OFF_TMR_LO_SET); // see R2
   assign wr_lo_clr = req.wr && (req.addr == `SPT_OFF_TMR_LO_CLR); // see R2
   assign wr_hi_set = req.wr && (req.addr == `SPT_OFF_TMR_HI_SET); // see R3
   assign wr_hi_clr = req.wr && (req.addr == `SPT_OFF_TMR_HI_CLR); // see R3
   assign wr_fen_set = req.wr && (req.addr == `SPT_OFF_FALL_EN_SET);
   assign wr_fen_clr = req.wr && (req.addr == `SPT_OFF_FALL_EN_CLR);
   assign wr_ren_set = req.wr && (req.addr == `SPT_OFF_RISE_EN_SET);
   assign wr_ren_clr = req.wr && (req.addr == `SPT_OFF_RISE_EN_CLR);
   assign wr_stat = req.wr && (req.addr == `SPT_OFF_IRQ_STAT);
   assign wr_mask = req.wr && (req.addr == `SPT_OFF_IRQ_MASK);

   // ==========================================================
   // Start value, bits 23 to 0
   logic [`SPT_LOAD_W-1:0] load_r;
   logic [`SPT_LOAD_W-1:0] load_nxt;

   always_comb begin
      load_nxt = load_r;
      if (wr_lo_set) begin
         load_nxt[15:0] = load_r[15:0] | req.wdata; // see R7
      end
      if (wr_lo_clr) begin
         load_nxt[15:0] = load_r[15:0] & ~req.wdata; // see R7
      end
      if (wr_hi_set) begin
         load_nxt[23:16] = load_r[23:16] | req.wdata[`SPT_LOAD_HI_W-1:0];
      end
      if (wr_hi_clr) begin
         load_nxt[23:16] = load_r[23:16] & ~req.wdata[`SPT_LOAD_HI_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         load_r <= `SPT_RST_LOAD;
      end else begin
         load_r <= load_nxt;
      end
   end

   // ==========================================================
   // Run control requests
   logic run_set_req;
   logic run_clr_req;

   assign run_set_req = wr_hi_set && req.wdata[`SPT_BIT_RUN_HI];
   assign run_clr_req = wr_hi_clr && req.wdata[`SPT_BIT_RUN_HI];

   // ==========================================================
   // Tick prescaler, 0.01 ms from the core clock
   logic [`SPT_PRE_W-1:0] pre_r;
   logic tick;
   logic start;

   // Cleared on start, so the first tick is a full 0.01 ms
   assign tick = (pre_r == `SPT_PRE_W'(`SPT_TICK_CYC - 1)); // see R8

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         pre_r <= '0;
      end else if (start || tick) begin
         pre_r <= '0; // see R10
      end else begin
         pre_r <= pre_r + `SPT_PRE_W'(1);
      end
   end

   // ==========================================================
   // Control state machine
   spt_state_t state_r;
   spt_state_t state_nxt;
   logic [`SPT_LOAD_W-1:0] cnt_r;
   logic expire;
   logic cnt_last;
   logic run;

   assign run = (state_r == SPT_COUNT);
   // Restart allowed in the expiry cycle; any other set while counting is ignored
   assign start = run_set_req && (!run || expire); // see R4
   // Start value zero expires at the first tick, like value one
   assign cnt_last = (cnt_r <= `SPT_LOAD_W'(1));
   assign expire = run && tick && cnt_last; // see R10

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SPT_IDLE: begin
            if (start) begin
               state_nxt = SPT_COUNT; // see R4
            end
         end
         SPT_COUNT: begin
            if (start) begin
               state_nxt = SPT_COUNT;
            end else if (run_clr_req) begin
               state_nxt = SPT_IDLE; // see R5
            end else if (expire) begin
               state_nxt = SPT_EXPIRED; // see R6
            end
         end
         SPT_EXPIRED: begin
            if (start) begin
               state_nxt = SPT_COUNT;
            end
         end
         default: begin
            state_nxt = SPT_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         state_r <= SPT_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Down counter
   // A stop freezes the count; only a new start reloads it
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         cnt_r <= `SPT_RST_LOAD;
      end else if (start) begin
         // Bits 23 to 16 carried by the start write itself are taken with the start
         cnt_r <= load_nxt; // see R4
      end else if (run && tick && (cnt_r != '0)) begin
         cnt_r <= cnt_r - `SPT_LOAD_W'(1); // see R10
      end
   end

   // ==========================================================
   // Timeout edges and edge enables
   logic timeout_lvl;
   logic tmo_rise;
   logic tmo_fall;
   logic rise_en_r;
   logic fall_en_r;
   logic timeout_rise_irq_enable;
   logic timeout_fall_irq_enable;

   assign timeout_lvl = (state_r == SPT_EXPIRED);
   assign tmo_rise = (state_r != SPT_EXPIRED) && (state_nxt == SPT_EXPIRED);
   assign tmo_fall = (state_r == SPT_EXPIRED) && (state_nxt != SPT_EXPIRED);
   assign timeout_rise_irq_enable = rise_en_r;
   assign timeout_fall_irq_enable = fall_en_r;

   // Set and clear never share a cycle, the port has one strobe per cycle
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rise_en_r <= 1'b0;
      end else if (wr_ren_set && req.wdata[`SPT_BIT_TMO_EN]) begin
         rise_en_r <= 1'b1;
      end else if (wr_ren_clr && req.wdata[`SPT_BIT_TMO_EN]) begin
         rise_en_r <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         fall_en_r <= 1'b0;
      end else if (wr_fen_set && req.wdata[`SPT_BIT_TMO_EN]) begin
         fall_en_r <= 1'b1;
      end else if (wr_fen_clr && req.wdata[`SPT_BIT_TMO_EN]) begin
         fall_en_r <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt status and mask
   logic [`SPT_IRQ_W-1:0] ev;
   logic [`SPT_IRQ_W-1:0] stat_r;
   logic [`SPT_IRQ_W-1:0] mask_r;

   assign ev[`SPT_IRQ_RISE] = tmo_rise && timeout_rise_irq_enable; // see R9
   assign ev[`SPT_IRQ_FALL] = tmo_fall && timeout_fall_irq_enable; // see R9

   genvar gi;
   generate
      for (gi = 0; gi < `SPT_IRQ_W; gi = gi + 1) begin : g_stat
         always_ff @(posedge REF_CLK) begin
            if (RESET) begin
               stat_r[gi] <= 1'b0;
            end else if (ev[gi]) begin
               // Set beats a simultaneous write-one-to-clear
               stat_r[gi] <= 1'b1;
            end else if (wr_stat && req.wdata[gi]) begin
               stat_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         mask_r <= `SPT_RST_IRQ;
      end else if (wr_mask) begin
         mask_r <= req.wdata[`SPT_IRQ_W-1:0];
      end
   end

   // Level output: stays high until software clears the status bit or its mask bit
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(stat_r & mask_r);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         TIMEOUT <= 1'b0;
      end else begin
         TIMEOUT <= timeout_lvl; // see R10
      end
   end

   // ==========================================================
   // Full 32-bit timer register, high half is bits 31 to 16
   logic timer_run_bit;
   logic [`SPT_LOAD_W-1:0] timer_load_value_alt;
   logic [31:0] session_timer_reg;
   logic [`SPT_DATA_W-1:0] timer_lo_half;
   logic [`SPT_DATA_W-1:0] timer_hi_half;

   assign timer_run_bit = run;
   assign timer_load_value_alt = load_r;
   // Reserved bits 30 to 24 are held at zero, never stored
   assign session_timer_reg = {timer_run_bit, 7'h00, timer_load_value_alt}; // see R1
   assign timer_lo_half = session_timer_reg[15:0];
   assign timer_hi_half = session_timer_reg[31:16];

   // ==========================================================
   // Read back, one cycle after the strobe
   logic [`SPT_DATA_W-1:0] rd_mux;

   always_comb begin
      rd_mux = '0;
      unique case (req.addr)
         `SPT_OFF_TMR_LO_SET, `SPT_OFF_TMR_LO_CLR: begin
            rd_mux = timer_lo_half; // see R1
         end
         `SPT_OFF_TMR_HI_SET, `SPT_OFF_TMR_HI_CLR: begin
            rd_mux = timer_hi_half; // see R1
         end
         `SPT_OFF_RISE_EN_SET, `SPT_OFF_RISE_EN_CLR: begin
            rd_mux[`SPT_BIT_TMO_EN] = timeout_rise_irq_enable;
         end
         `SPT_OFF_FALL_EN_SET, `SPT_OFF_FALL_EN_CLR: begin
            rd_mux[`SPT_BIT_TMO_EN] = timeout_fall_irq_enable;
         end
         `SPT_OFF_IRQ_STAT: begin
            rd_mux[`SPT_IRQ_W-1:0] = stat_r;
         end
         `SPT_OFF_IRQ_MASK: begin
            rd_mux[`SPT_IRQ_W-1:0] = mask_r;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         RDATA <= '0;
      end else if (req.rd) begin
         RDATA <= rd_mux;
      end else begin
         // Data only valid in the cycle after the strobe
         RDATA <= '0;
      end
   end

endmodule : spt_timer

`default_nettype wire

/* tb/spt_timer_props.sv */
/*
 Checker of the session protocol timer port behaviour.
 Assumes the spt_timer ports and spt_defines.svh.
*/
`timescale 1ns/1ps
`include "spt_defines.svh"
`default_nettype none

module spt_timer_props (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // Register port
   input wire logic [`SPT_ADDR_W-1:0] ADDR,
   input wire logic [`SPT_DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [`SPT_DATA_W-1:0] RDATA,
   // Status
   input wire logic TIMEOUT,
   input wire logic IRQ
);
   // ==========================================================
   // Cycles since the last start write, saturating
   logic [11:0] age_r;
   logic start;
   assign start = WR && ADDR == 8'hFC && WDATA[15];
   always_ff @(posedge REF_CLK) begin
      if (RESET || start) age_r <= 12'h000;
      else if (age_r != 12'hFFF) age_r <= age_r + 12'h001;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   // ==========================================================
   // Properties
   a_rdata_idle: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data outside read cycle");
   a_odd_unmapped: assert property (RD && ADDR[0] |=> RDATA == 16'h0000)
      else $error("odd address read not zero");
   a_hi_reserved: assert property (RD && ADDR == 8'hFC |=> RDATA[14:8] == 7'h00)
      else $error("reserved high bits not zero");
   a_start_clears: assert property (start && TIMEOUT |-> ##2 !TIMEOUT)
      else $error("start left timeout set");
   a_timeout_hold: assert property (TIMEOUT && !start && !$past(start) |=> TIMEOUT)
      else $error("timeout dropped without start");
   a_timeout_min: assert property ($rose(TIMEOUT) |-> age_r >= 12'h4E3)
      else $error("timeout earlier than one tick");
   a_irq_cause: assert property ($rose(IRQ) |-> $past(WR) || $past(WR, 2)
      || $changed(TIMEOUT))
      else $error("interrupt without cause");
   a_irq_masked: assert property (WR && ADDR == 8'hE6 && WDATA[1:0] == 2'h0
      |=> ##1 !IRQ)
      else $error("interrupt while masked");
   a_reset_quiet: assert property (@(posedge REF_CLK) $fell(RESET) |-> !IRQ && !TIMEOUT)
      else $error("outputs active after reset");
endmodule : spt_timer_props

bind spt_timer spt_timer_props spt_timer_props_inst (.REF_CLK(REF_CLK), .RESET(RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TIMEOUT(TIMEOUT),
   .IRQ(IRQ));

`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench of the session protocol timer.
 Assumes a 125 MHz clock and a one-cycle register port.
*/
`timescale 1ns/1ps
`include "spt_defines.svh"
`default_nettype none

module tb;
   // ==========================================================
   // Signals
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic timeout;
   logic irq;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;

   spt_timer spt_timer_inst (.REF_CLK(ref_clk), .RESET(reset), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TIMEOUT(timeout), .IRQ(irq));

   initial forever #4 ref_clk = ~ref_clk;

   // ==========================================================
   // Tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr16

   task automatic rd16(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd16

   // Flags are sampled settled, one step after the edge
   task automatic flags(input int n, input logic [1:0] exp);
      repeat (n) @(posedge ref_clk);
      #1;
      chk({14'h0000, timeout, irq}, {14'h0000, exp});
   endtask : flags

   // Long ceiling: two runs of two ticks, one run stopped after 100 cycles, three long flag waits plus register traffic
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ==========================================================
   // Sequence
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd16(8'hF8, 16'h0000);
      rd16(8'hFC, 16'h0000);
      rd16(8'hE4, 16'h0000);
      rd16(8'hF4, 16'h0000);
      rd16(8'h10, 16'h0000);
      wr16(8'hF8, 16'h1234);
      wr16(8'hFA, 16'h0204);
      rd16(8'hFA, 16'h1030);
      wr16(8'hFC, 16'h7F56);
      rd16(8'hFC, 16'h0056);
      wr16(8'hFE, 16'h0056);
      rd16(8'hFE, 16'h0000);
      wr16(8'hFA, 16'hFFFF);
      wr16(8'hF8, 16'h0002);
      rd16(8'hF8, 16'h0002);
      wr16(8'hF4, 16'h0200);
      wr16(8'hF0, 16'h0200);
      rd16(8'hF0, 16'h0200);
      wr16(8'hE6, 16'h0003);
      wr16(8'hFC, 16'h8000);
      rd16(8'hFC, 16'h8000);
      // Two ticks of 1250 cycles: expiry 2500 edges after the start write
      flags(2498, 2'b00);
      flags(1, 2'b11);
      rd16(8'hFC, 16'h0000);
      rd16(8'hE4, 16'h0001);
      wr16(8'hE4, 16'h0001);
      flags(2, 2'b10);
      // Restart from expiry is the falling edge of timeout
      wr16(8'hFC, 16'h8000);
      repeat (100) @(posedge ref_clk);
      wr16(8'hFE, 16'h8000);
      rd16(8'hFC, 16'h0000);
      flags(2600, 2'b01);
      rd16(8'hE4, 16'h0002);
      wr16(8'hE6, 16'h0000);
      flags(2, 2'b00);
      wr16(8'hE4, 16'h0002);
      wr16(8'hF6, 16'h0200);
      rd16(8'hF4, 16'h0000);
      wr16(8'hF2, 16'h0200);
      rd16(8'hF2, 16'h0000);
      wr16(8'hE6, 16'h0003);
      wr16(8'hFC, 16'h8000);
      flags(2600, 2'b10);
      rd16(8'hE4, 16'h0000);
      // Restart from expiry with the fall enable cleared latches nothing
      wr16(8'hFC, 16'h8000);
      rd16(8'hE4, 16'h0000);
      print_verdict();
   end
endmodule : tb

`default_nettype wire
